/* shared/sps_pkg.sv */
// constants, sense and control carriers, states of the protection sequencer
package sps_pkg;

  // timebase
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS       = 500;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 5;

  // documented intervals in their own units
  localparam int LINE_LOW_BLANKING_MS  = 50;
  localparam int MAINS_LOSS_TIMEOUT_MS = 100;
  localparam int REMOTE_PULL_MS        = 100;
  localparam int SOFT_START_MS         = 4;
  localparam int FAULT_BLANKING_NS     = 27500;
  localparam int SUPPLY_GROUND_US      = 10;

  function automatic int ceilDiv(input int num, input int den);
    return (num + den - 1) / den;
  endfunction

  // intervals as counts of ticks, least times rounded up
  localparam int LINE_LOW_TICKS   = ceilDiv(LINE_LOW_BLANKING_MS * 1000000, TICK_NS);
  localparam int MAINS_LOSS_TICKS = ceilDiv(MAINS_LOSS_TIMEOUT_MS * 1000000, TICK_NS);
  localparam int REMOTE_PULL_TICKS = ceilDiv(REMOTE_PULL_MS * 1000000, TICK_NS);
  localparam int SOFT_START_TICKS = ceilDiv(SOFT_START_MS * 1000000, TICK_NS);
  localparam int FAULT_TICKS      = ceilDiv(FAULT_BLANKING_NS, TICK_NS);
  localparam int GROUND_TICKS     = ceilDiv(SUPPLY_GROUND_US * 1000, TICK_NS);
  localparam int TIMER_W          = 18;

  // digitised comparator results from the analog front end
  typedef struct packed {
    logic lineAboveStop;
    logic lineAboveStart;
    logic mainsPresent;
    logic remoteAboveSleep;
    logic remoteBelowRestart;
    logic faultAboveUpper;
    logic faultBelowLower;
    logic supplyAboveInhibit;
    logic supplyAboveTurnOn;
  } sps_sense_t;

  localparam sps_sense_t SENSE_RESET = '0;

  // controls to the power stage and analog blocks
  typedef struct packed {
    logic gateEnable;
    logic supplyHold;
    logic supplyGround;
    logic startCurrentEn;
    logic reducedCurrent;
    logic hvSourceEn;
    logic dischargeSwitch;
    logic remotePullDown;
    logic otpBiasEn;
    logic softStart;
    logic deepSleepMode;
    logic latchedOff;
    logic lineLowFault;
  } sps_ctrl_t;

  localparam sps_ctrl_t CTRL_RESET = '0;

  typedef enum logic [7:0] {
    ST_CHARGE = 8'h01,
    ST_PAUSE  = 8'h02,
    ST_SOFT   = 8'h04,
    ST_RUN    = 8'h08,
    ST_BROWN  = 8'h10,
    ST_GROUND = 8'h20,
    ST_SLEEP  = 8'h40,
    ST_LATCH  = 8'h80
  } sps_state_t;

endpackage

/* rtl/sps_qual_timer.sv */
// qualification timer: counts ticks while a condition holds
`timescale 1ns/100ps
module sps_qual_timer #(
  parameter int W     = 18,
  parameter int LIMIT = 100
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // timing
  input  wire logic tick,
  input  wire logic cond,
  output logic      done
);

  localparam logic [W-1:0] LIMIT_V = W'(LIMIT);

  logic [W-1:0] count;

  // restart when the condition drops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (!cond) begin
      count <= '0;
    end else if (tick && count != LIMIT_V) begin
      count <= count + W'(1);
    end
  end

  assign done = cond && (count == LIMIT_V);

endmodule

/* rtl/sps_sequencer.sv */
// protection and power-state sequencer of a flyback controller
`timescale 1ns/100ps
module sps_sequencer
  import sps_pkg::*;
#(
  parameter int LINE_LOW_LIMIT    = LINE_LOW_TICKS,
  parameter int MAINS_LOSS_LIMIT  = MAINS_LOSS_TICKS,
  parameter int REMOTE_PULL_LIMIT = REMOTE_PULL_TICKS,
  parameter int SOFT_START_LIMIT  = SOFT_START_TICKS
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // comparator results, asynchronous
  input  wire sps_sense_t senseRaw,
  // controls to the power stage
  output sps_ctrl_t       ctrlOut,
  // state for observation
  output sps_state_t      stateOut
);

  sps_sense_t senseMeta;
  sps_sense_t sense;
  logic [TICK_W-1:0] tickCount;
  logic tick;
  sps_state_t state;
  sps_state_t next_state;
  logic recovering;
  logic selfRelax;
  logic pullActive;
  logic dischargeActive;
  logic lineLowDone;
  logic mainsLossDone;
  logic upperDone;
  logic lowerDone;
  logic softDone;
  logic groundDone;
  logic pullDone;
  logic faultHit;
  logic restartEvent;
  logic switching;
  sps_ctrl_t next_ctrl;

  // two-stage synchroniser on the comparator inputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      senseMeta <= SENSE_RESET;
      sense     <= SENSE_RESET;
    end else begin
      senseMeta <= senseRaw;
      sense     <= senseMeta;
    end
  end

  // timebase divider
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tickCount <= '0;
    end else if (tickCount == TICK_W'(TICK_CYCLES - 1)) begin
      tickCount <= '0;
    end else begin
      tickCount <= tickCount + TICK_W'(1);
    end
  end

  assign tick = (tickCount == TICK_W'(TICK_CYCLES - 1));

  assign switching = (state == ST_SOFT) || (state == ST_RUN);

  // qualification timers
  sps_qual_timer #(.W(TIMER_W), .LIMIT(LINE_LOW_LIMIT)) u_lineLow (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .cond     (!sense.lineAboveStop),
    .done     (lineLowDone)
  );

  sps_qual_timer #(.W(TIMER_W), .LIMIT(MAINS_LOSS_LIMIT)) u_mainsLoss (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .cond     (!sense.mainsPresent),
    .done     (mainsLossDone)
  );

  sps_qual_timer #(.W(TIMER_W), .LIMIT(FAULT_TICKS)) u_upper (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .cond     (sense.faultAboveUpper && switching),
    .done     (upperDone)
  );

  sps_qual_timer #(.W(TIMER_W), .LIMIT(FAULT_TICKS)) u_lower (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .cond     (sense.faultBelowLower && state == ST_RUN),
    .done     (lowerDone)
  );

  sps_qual_timer #(.W(TIMER_W), .LIMIT(SOFT_START_LIMIT)) u_soft (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .cond     (state == ST_SOFT),
    .done     (softDone)
  );

  sps_qual_timer #(.W(TIMER_W), .LIMIT(GROUND_TICKS)) u_ground (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .cond     (state == ST_GROUND),
    .done     (groundDone)
  );

  sps_qual_timer #(.W(TIMER_W), .LIMIT(REMOTE_PULL_LIMIT)) u_pull (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .cond     (pullActive && !restartEvent),
    .done     (pullDone)
  );

  assign faultHit = upperDone || lowerDone;

  // restart from ground only, never from power-up or sleep
  assign restartEvent = (state == ST_GROUND) && groundDone;

  // sequencer state
  always_comb begin
    next_state = state;
    case (state)
      ST_CHARGE: begin
        if (lineLowDone) begin
          next_state = ST_PAUSE;
        end else if (sense.supplyAboveTurnOn) begin
          next_state = ST_SOFT;
        end
      end
      ST_PAUSE: begin
        if (sense.lineAboveStart) begin
          next_state = ST_CHARGE;
        end
      end
      ST_SOFT, ST_RUN: begin
        if (faultHit) begin
          next_state = ST_LATCH;
        end else if (lineLowDone) begin
          next_state = ST_BROWN;
        end else if (sense.remoteAboveSleep) begin
          next_state = ST_SLEEP;
        end else if (state == ST_SOFT && softDone) begin
          next_state = ST_RUN;
        end
      end
      ST_BROWN: begin
        if (sense.lineAboveStart) begin
          next_state = ST_GROUND;
        end
      end
      ST_GROUND: begin
        if (groundDone) begin
          next_state = ST_CHARGE;
        end
      end
      ST_SLEEP: begin
        if (sense.remoteBelowRestart) begin
          next_state = ST_CHARGE;
        end
      end
      ST_LATCH: begin
        if (lineLowDone || dischargeActive) begin
          next_state = ST_BROWN;
        end
      end
      default: begin
        next_state = ST_CHARGE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_CHARGE;
    end else begin
      state <= next_state;
    end
  end

  // recovery flag: full charging current after brown-out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      recovering <= 1'b0;
    end else if (state == ST_GROUND) begin
      recovering <= 1'b1;
    end else if (state == ST_SOFT) begin
      recovering <= 1'b0;
    end
  end

  // sleep restart marker, suppresses the remote pull-down
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selfRelax <= 1'b0;
    end else if (state == ST_SLEEP) begin
      selfRelax <= 1'b1;
    end else if (restartEvent) begin
      selfRelax <= 1'b0;
    end
  end

  // remote pull-down window, armed at power-up and each restart
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pullActive <= 1'b1;
    end else if (restartEvent) begin
      pullActive <= 1'b1;
    end else if (pullDone || state == ST_SLEEP) begin
      pullActive <= 1'b0;
    end
  end

  // mains-loss discharge, independent of the sequencer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dischargeActive <= 1'b0;
    end else if (mainsLossDone) begin
      dischargeActive <= 1'b1;
    end else if (sense.mainsPresent) begin
      dischargeActive <= 1'b0;
    end
  end

  // control outputs
  always_comb begin
    next_ctrl                = CTRL_RESET;
    next_ctrl.gateEnable     = switching && next_state != ST_LATCH;
    next_ctrl.supplyHold     = (state == ST_BROWN) || (state == ST_LATCH);
    next_ctrl.supplyGround   = (state == ST_GROUND);
    next_ctrl.startCurrentEn = (state == ST_CHARGE);
    next_ctrl.reducedCurrent = (state == ST_CHARGE) && !sense.supplyAboveInhibit && !recovering;
    next_ctrl.hvSourceEn     = (state == ST_CHARGE) || next_ctrl.supplyHold || dischargeActive;
    next_ctrl.dischargeSwitch = dischargeActive;
    next_ctrl.remotePullDown = pullActive && !selfRelax;
    next_ctrl.otpBiasEn      = switching || (state == ST_LATCH);
    next_ctrl.softStart      = (state == ST_SOFT);
    next_ctrl.deepSleepMode  = (state == ST_SLEEP);
    next_ctrl.latchedOff     = (state == ST_LATCH);
    next_ctrl.lineLowFault   = lineLowDone;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrlOut <= CTRL_RESET;
    end else begin
      ctrlOut <= next_ctrl;
    end
  end

  assign stateOut = state;

  // checks
  sequence seqBrownReturn;
    state == ST_BROWN && sense.lineAboveStart;
  endsequence

  sequence seqGroundThenCharge;
    state == ST_GROUND ##[1:520] state == ST_CHARGE;
  endsequence

  AST_LINE_LOW_STOP: assert property (@(posedge core_clk) disable iff (rst)
    (switching && lineLowDone && !faultHit) |=> state == ST_BROWN ##1 !ctrlOut.gateEnable && ctrlOut.supplyHold)
    else $error("line low did not stop switching");

  AST_BROWN_RECOVER: assert property (@(posedge core_clk) disable iff (rst)
    seqBrownReturn |=> seqGroundThenCharge)
    else $error("brown-out recovery did not ground and restart");

  AST_FULL_CURRENT_RECOVERY: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_CHARGE && recovering) |=> !ctrlOut.reducedCurrent)
    else $error("reduced current during recovery");

  AST_PAUSE_NO_GROUND: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_CHARGE && lineLowDone) |=> state == ST_PAUSE ##1 !ctrlOut.supplyGround)
    else $error("charge pause grounded the supply");

  AST_DISCHARGE_ON_LOSS: assert property (@(posedge core_clk) disable iff (rst)
    mainsLossDone |=> ##1 ctrlOut.dischargeSwitch && ctrlOut.hvSourceEn)
    else $error("discharge not enabled after mains loss");

  AST_NO_EARLY_DISCHARGE: assert property (@(posedge core_clk) disable iff (rst)
    $rose(dischargeActive) |-> $past(mainsLossDone))
    else $error("discharge without mains-loss timeout");

  AST_SLEEP_ENTRY: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_RUN && sense.remoteAboveSleep && !faultHit && !lineLowDone)
      |=> state == ST_SLEEP ##1 !ctrlOut.gateEnable)
    else $error("sleep request not taken");

  AST_SLEEP_EXIT: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_SLEEP && sense.remoteBelowRestart) |=> state == ST_CHARGE)
    else $error("sleep exit missed");

  AST_NO_PULL_AFTER_SLEEP: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_SLEEP) |=> ##1 !ctrlOut.remotePullDown)
    else $error("remote pulled low on sleep cycle");

  AST_UPPER_LATCH: assert property (@(posedge core_clk) disable iff (rst)
    (switching && upperDone) |=> state == ST_LATCH ##1 ctrlOut.latchedOff)
    else $error("upper fault did not latch");

  AST_LOWER_IGNORED_SOFT: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_SOFT && sense.faultBelowLower && !upperDone) |=> state != ST_LATCH)
    else $error("lower fault acted during soft-start");

  AST_LATCH_GATE_OFF: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state == ST_LATCH) |-> !ctrlOut.gateEnable ##1 ctrlOut.supplyHold)
    else $error("gate still on after latch");

  AST_LATCH_HELD: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_LATCH && !lineLowDone && !dischargeActive) |=> state == ST_LATCH)
    else $error("latch left without unplug");

  AST_LATCH_NO_SLEEP: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_LATCH) |=> state != ST_SLEEP)
    else $error("sleep entered from latch");

  AST_OTP_BIAS_POWERUP: assert property (@(posedge core_clk) disable iff (rst)
    (state == ST_CHARGE) |=> !ctrlOut.otpBiasEn)
    else $error("overtemperature bias on during power-up");

endmodule

/* tb/sps_power_stage.sv */
// behavioural supply capacitor and auxiliary winding of the power stage
`timescale 1ns/100ps
module sps_power_stage
  import sps_pkg::*;
#(
  parameter int STEP = 5
) (
  // clock and commands
  input  wire logic      core_clk,
  input  wire logic      stall,
  input  wire sps_ctrl_t ctrl,
  // supply comparators
  output logic           aboveInhibit,
  output logic           aboveTurnOn
);
  int vcc = 0;

  // supply level in tenths of a volt
  always @(posedge core_clk) begin
    if (ctrl.supplyGround)
      vcc <= 0;
    else if (ctrl.gateEnable)
      vcc <= 160;
    else if (ctrl.supplyHold)
      vcc <= 55;
    else if (ctrl.startCurrentEn && !stall)
      vcc <= vcc + (ctrl.reducedCurrent ? 1 : STEP);
    else if (vcc > 0 && !ctrl.startCurrentEn)
      vcc <= vcc - 1;
  end

  assign aboveInhibit = vcc >= 10;
  assign aboveTurnOn  = vcc >= 150;
endmodule

/* tb/sps_sequencer_test.sv */
// self-checking bench of the protection sequencer
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module sps_sequencer_test
  import sps_pkg::*;
;
  localparam int LL = 4;
  localparam int ML = 6;
  localparam int SS = 10;
  localparam int T  = TICK_CYCLES;
  localparam int FT = FAULT_TICKS;

  logic       core_clk;
  logic       rst;
  logic       stall;
  logic       inh;
  logic       ton;
  sps_sense_t drv;
  sps_sense_t senseRaw;
  sps_ctrl_t  ctrlOut;
  sps_state_t stateOut;
  sps_state_t lastSt = ST_CHARGE;
  sps_state_t expQ[$];
  int         failCount = 0;
  int         totalChecks = 0;
  int         waited;

  sps_sequencer #(.LINE_LOW_LIMIT(LL), .MAINS_LOSS_LIMIT(ML), .REMOTE_PULL_LIMIT(8),
    .SOFT_START_LIMIT(SS)) i_dut (.core_clk(core_clk), .rst(rst), .senseRaw(senseRaw),
    .ctrlOut(ctrlOut), .stateOut(stateOut));

  sps_power_stage #(.STEP(5)) i_stage (.core_clk(core_clk), .stall(stall), .ctrl(ctrlOut),
    .aboveInhibit(inh), .aboveTurnOn(ton));

  always_comb begin
    senseRaw = drv;
    senseRaw.supplyAboveInhibit = inh;
    senseRaw.supplyAboveTurnOn = ton;
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    totalChecks++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wt(int c);
    repeat (c) @(negedge core_clk);
  endtask

  // note the expected state, then wait for it
  task automatic step(sps_state_t s, int lim);
    expQ.push_back(s);
    waited = 0;
    while (stateOut !== s && waited < lim) begin
      @(negedge core_clk);
      waited++;
    end
    `CHK("state reached", s, stateOut);
  endtask

  task automatic line(logic v);
    drv.lineAboveStop  = v;
    drv.lineAboveStart = v;
  endtask

  task automatic up();
    step(ST_SOFT, 400);
    step(ST_RUN, SS * T + 10);
  endtask

  // any state change is compared with the oldest note
  always @(posedge core_clk) begin
    if (!rst && stateOut !== lastSt) begin
      lastSt <= stateOut;
      if (expQ.size() == 0)
        `CHK("unexpected state", 8'h00, stateOut);
      else
        `CHK("state order", expQ.pop_front(), stateOut);
    end
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    failCount++;
    closeOut();
  end

  initial begin
    drv = 9'h1d0;
    rst = 1'b1;
    stall = 1'b0;
    void'($urandom(59));
    wt(12);
    rst = 1'b0;
    wt(3);
    `CHK("pull at power-up", 1'b1, ctrlOut.remotePullDown);
    `CHK("reduced at power-up", 1'b1, ctrlOut.reducedCurrent);
    `CHK("bias in charge", 1'b0, ctrlOut.otpBiasEn);
    step(ST_SOFT, 400);
    wt(1);
    `CHK("soft flag", 1'b1, ctrlOut.softStart);
    `CHK("bias at turn-on", 1'b1, ctrlOut.otpBiasEn);
    step(ST_RUN, SS * T + 10);
    `CHK("soft length", 1'b1, waited >= (SS - 1) * T - 2);
    $display("startup done");

    // short dip, then a real brown-out
    line(1'b0);
    wt($urandom_range((LL - 1) * T - 5, 5));
    line(1'b1);
    wt(20);
    line(1'b0);
    step(ST_BROWN, LL * T + 10);
    wt(1);
    `CHK("gate in brown-out", 1'b0, ctrlOut.gateEnable);
    `CHK("hold in brown-out", 1'b1, ctrlOut.supplyHold);
    `CHK("line fault", 1'b1, ctrlOut.lineLowFault);
    drv.lineAboveStop = 1'b1;
    wt(50);
    stall = 1'b1;
    drv.lineAboveStart = 1'b1;
    step(ST_GROUND, 10);
    wt(1);
    `CHK("ground on recovery", 1'b1, ctrlOut.supplyGround);
    step(ST_CHARGE, GROUND_TICKS * T + 10);
    wt(2);
    `CHK("reduced on recovery", 1'b0, ctrlOut.reducedCurrent);
    `CHK("charge on recovery", 1'b1, ctrlOut.startCurrentEn);
    `CHK("pull on recovery", 1'b1, ctrlOut.remotePullDown);
    line(1'b0);
    step(ST_PAUSE, LL * T + 10);
    wt(1);
    `CHK("no ground in pause", 1'b0, ctrlOut.supplyGround);
    `CHK("no charge in pause", 1'b0, ctrlOut.startCurrentEn);
    line(1'b1);
    step(ST_CHARGE, 10);
    stall = 1'b0;
    up();
    $display("brown-out done");

    // sleep with a mains loss inside it
    drv.remoteBelowRestart = 1'b0;
    drv.remoteAboveSleep = 1'b1;
    step(ST_SLEEP, 10);
    wt(1);
    `CHK("gate in sleep", 1'b0, ctrlOut.gateEnable);
    `CHK("sleep flag", 1'b1, ctrlOut.deepSleepMode);
    drv.mainsPresent = 1'b0;
    wt((ML - 1) * T - 5);
    `CHK("early discharge", 1'b0, ctrlOut.dischargeSwitch);
    waited = 0;
    while (ctrlOut.dischargeSwitch !== 1'b1 && waited < 40) begin
      wt(1);
      waited++;
    end
    `CHK("discharge in sleep", 1'b1, ctrlOut.dischargeSwitch);
    `CHK("source on discharge", 1'b1, ctrlOut.hvSourceEn);
    drv.mainsPresent = 1'b1;
    wt(5);
    `CHK("discharge ends", 1'b0, ctrlOut.dischargeSwitch);
    drv.remoteAboveSleep = 1'b0;
    drv.remoteBelowRestart = 1'b1;
    step(ST_CHARGE, 10);
    wt(2);
    `CHK("no pull after sleep", 1'b0, ctrlOut.remotePullDown);
    `CHK("sleep left", 1'b0, ctrlOut.deepSleepMode);
    up();
    $display("sleep done");

    // upper fault: short spike, then latch
    drv.faultAboveUpper = 1'b1;
    wt($urandom_range((FT - 1) * T - 5, 5));
    drv.faultAboveUpper = 1'b0;
    wt(20);
    drv.faultAboveUpper = 1'b1;
    step(ST_LATCH, FT * T + 10);
    `CHK("upper blanking", 1'b1, waited >= (FT - 1) * T - 2);
    `CHK("gate on latch", 1'b0, ctrlOut.gateEnable);
    wt(1);
    `CHK("hold on latch", 1'b1, ctrlOut.supplyHold);
    `CHK("latch flag", 1'b1, ctrlOut.latchedOff);
    drv.faultAboveUpper = 1'b0;
    drv.remoteBelowRestart = 1'b0;
    drv.remoteAboveSleep = 1'b1;
    wt(40);
    `CHK("no sleep in latch", 1'b0, ctrlOut.deepSleepMode);
    drv.remoteAboveSleep = 1'b0;
    drv.remoteBelowRestart = 1'b1;
    line(1'b0);
    step(ST_BROWN, LL * T + 10);
    line(1'b1);
    step(ST_GROUND, 10);
    step(ST_CHARGE, GROUND_TICKS * T + 10);
    step(ST_SOFT, 400);
    $display("upper fault done");

    // lower fault held through soft-start, then latch
    drv.faultBelowLower = 1'b1;
    step(ST_RUN, SS * T + 10);
    step(ST_LATCH, FT * T + 10);
    `CHK("ignored in soft", 1'b1, waited >= (FT - 1) * T - 2);
    drv.faultBelowLower = 1'b0;
    drv.mainsPresent = 1'b0;
    step(ST_BROWN, ML * T + 10);
    drv.mainsPresent = 1'b1;
    step(ST_GROUND, 10);
    step(ST_CHARGE, GROUND_TICKS * T + 10);
    up();
    $display("lower fault done");
    closeOut();
  end
endmodule
